// ---- inc/lpcc_cfg.svh ----
// Constants of the light pen coordinate capture block.
`ifndef LPCC_CFG_SVH
`define LPCC_CFG_SVH

// Bus window and word offsets.
`define LPCC_WIN_TAG        28'h0000220
`define LPCC_OFS_HORIZ_LSB  4'h0
`define LPCC_OFS_HORIZ_UP   4'h4
`define LPCC_OFS_LINE       4'h8
`define LPCC_OFS_ADAPTER    4'hc
`define LPCC_HTRANS_NONSEQ  2'h2
`define LPCC_HSIZE_WORD     3'h2

// Adapter register field positions.
`define LPCC_MODE_LSB       0
`define LPCC_MODE_MSB       6
`define LPCC_PORTB_LSB      8
`define LPCC_PORTB_MSB      15
`define LPCC_TOUCH_FLAG_BIT 16
`define LPCC_HIT_FLAG_BIT   17
`define LPCC_TOUCH_EN_BIT   18
`define LPCC_HIT_EN_BIT     19

// Reset values and counter limits.
`define LPCC_MODE_RST       7'h02
`define LPCC_PORTB_RST      8'h30
`define LPCC_BIT_LAST       9'h1ff
`define LPCC_DG_TERMINAL    4'hf
`define LPCC_SRC_GFX        2'h0

`endif

// ---- inc/lpcc_pkg.sv ----
// Types shared by the light pen coordinate capture block.
package lpcc_pkg;

  // Lockout choice carried in the two lowest mode bits.
  typedef enum logic [1:0] {
    LPCC_LOCK_FRAME = 2'h0,
    LPCC_LOCK_LINE  = 2'h1,
    LPCC_LOCK_NONE  = 2'h3,
    LPCC_LOCK_OFF2  = 2'h2
  } lpcc_lock_e;

  // Latched pen position.
  typedef struct packed {
    logic [7:0] line;
    logic [8:0] horiz;
  } lpcc_coord_s;

  // Address phase held for the data phase.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] ofs;
  } lpcc_aphase_s;

  // Adapter state: mode port, control port and pen flags.
  typedef struct packed {
    logic [6:0] mode;
    logic [7:0] portb;
    logic       touch_flag;
    logic       hit_flag;
    logic       touch_en;
    logic       hit_en;
  } lpcc_adapter_s;

endpackage

// ---- hdl/lpcc_top.sv ----
// Light pen coordinate counters, hit deglitcher, mode adapter and AHB-Lite slave.
`timescale 1ns/10ps
`include "lpcc_cfg.svh"

// Contract
// - Count pixel bit position per line, up to 512, on the pixel bit clock.
// - On each capture pulse copy the horizontal bit count into holding latches.
// - Read horizontal LSB under one enable, upper eight bits under another.
// - Count line increment pulses in eight bits, sourced through the sync multiplexer.
// - Latch line count on capture; drive it on the bus under line read.
// - Deglitch counter rests at terminal count, counting disabled, until a qualified hit.
// - Qualified hit resets deglitch counter to zero; it then counts line pulses.
// - After configured lines, next hit arms first stage; next bit clock makes capture.
// - No hit on the qualifying line: counter runs to terminal, no capture.
// - Capture stage lockable for rest of line or frame, chosen by two mode bits.
// - Lockout code 0 means frame, 1 means line, 2 means no lockout.
// - Adapter first port is all outputs and carries the seven mode bits.
// - Second port low nibble sets lines ignored after vertical sync, external sync.
// - Second port high nibble sets successive hit lines the deglitcher needs.
// - Two interrupt outputs, one from touch, one from hit, via adapter inputs.
// - Touch-for-hit mode requires touch and hit both active; both active low.
// - Cursor mode uses the hit to invert picture information at the pen.
// - Cursor inversion suppressed under touch; invert mode bit inverts whole picture.
// - Answer a 16-byte window at 2200 hex, qualified by a valid memory cycle.
// - Link option adds a processor address signal, answering one or both processors.
// - Register select, read/write and low four address bits; decode read enables.
module lpcc_top (
  // Clock and reset.
  input  wire logic                  I_REF_CLK,
  input  wire logic                  I_NRST,
  // AHB-Lite slave.
  input  wire logic                  I_HSEL,
  input  wire logic [31:0]           I_HADDR,
  input  wire logic [1:0]            I_HTRANS,
  input  wire logic                  I_HWRITE,
  input  wire logic [2:0]            I_HSIZE,
  input  wire logic [31:0]           I_HWDATA,
  input  wire logic                  I_HREADY,
  output logic                       O_HREADYOUT,
  output logic                       O_HRESP,
  output logic [31:0]                O_HRDATA,
  // Processor decode link option.
  input  wire logic                  I_LINK_PROC_UNIQUE,
  input  wire logic                  I_PROC_ADDR_SEL,
  // Display timing from the graphics controller and other sync sources.
  input  wire logic                  I_PIXEL_BIT_CLOCK,
  input  wire logic                  I_ALT_LINE_PULSE,
  input  wire logic                  I_LINE_RESET,
  input  wire logic                  I_FRAME_RESET,
  // Light pen, both active low.
  input  wire logic                  I_PEN_HIT_N,
  input  wire logic                  I_PEN_TOUCH_N,
  // Outputs to the display and the rest of the system.
  output logic [6:0]                 O_MODE_SELECT_BITS,
  output logic [3:0]                 O_SYNC_SKIP_LINES,
  output logic                       O_INVERT,
  output logic                       O_LINE_CLOCK_TO_TIMER,
  output logic                       O_COORDINATE_CAPTURE_PULSE,
  output logic                       O_TOUCH_IRQ,
  output logic                       O_HIT_IRQ
);
  import lpcc_pkg::*;

  logic [8:0]    bit_cnt_r;
  logic          line_finish_r;
  logic [7:0]    line_cnt_r;
  logic [3:0]    dg_cnt_r;
  logic          arm_r;
  logic          stb_r;
  logic          locked_r;
  logic          qhit_d_r;
  logic          hit_d_r;
  logic          touch_d_r;
  logic          invert_r;
  logic          line_clock_to_timer_r;
  lpcc_coord_s   coord_r;
  lpcc_aphase_s  aph_r;
  lpcc_adapter_s adp_r;
  logic [31:0]   hrdata_r;

  logic          line_increment_pulse;
  logic          qualified_pen_hit;
  logic          qhit_pulse;
  logic          deglitch_terminal_count;
  logic          addr_hit;
  logic          aph_valid;
  lpcc_lock_e    lock_sel;
  logic [31:0]   adapter_word;

  // Decode of a word offset to its read value, used by the read data register.
  function automatic logic [31:0] read_value(input logic [3:0] ofs, input lpcc_coord_s c,
                                             input logic [31:0] adp);
    logic [31:0] v;
    v = 32'h0;
    unique case (ofs)
      `LPCC_OFS_HORIZ_LSB: v = {31'h0, c.horiz[0]};
      `LPCC_OFS_HORIZ_UP:  v = {24'h0, c.horiz[8:1]};
      `LPCC_OFS_LINE:      v = {24'h0, c.line};
      `LPCC_OFS_ADAPTER:   v = adp;
      default:             v = 32'h0;
    endcase
    return v;
  endfunction

  assign lock_sel                = lpcc_lock_e'(adp_r.mode[1:0]);
  assign deglitch_terminal_count = (dg_cnt_r == `LPCC_DG_TERMINAL);
  // Source 0 is the own end-of-line; any other sync source supplies its own line pulse.
  assign line_increment_pulse    = (adp_r.mode[3:2] == `LPCC_SRC_GFX) ? line_finish_r
                                                                      : I_ALT_LINE_PULSE;
  assign qualified_pen_hit       = !I_PEN_HIT_N && (!adp_r.mode[4] || !I_PEN_TOUCH_N);
  assign qhit_pulse              = qualified_pen_hit && !qhit_d_r;
  assign adapter_word            = {12'h0, adp_r.hit_en, adp_r.touch_en, adp_r.hit_flag,
                                    adp_r.touch_flag, adp_r.portb, 1'b0, adp_r.mode};
  // Window tag covers the 16 bytes; the link option gates in a processor address line.
  assign addr_hit  = I_HSEL && (I_HADDR[31:4] == `LPCC_WIN_TAG) &&
                     (!I_LINK_PROC_UNIQUE || I_PROC_ADDR_SEL);
  assign aph_valid = addr_hit && I_HREADY && (I_HTRANS == `LPCC_HTRANS_NONSEQ);

  // Pixel bit counter; it stops at the last position, as the bit oscillator does.
  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST || I_LINE_RESET) begin
      bit_cnt_r     <= 9'h0;
      line_finish_r <= 1'b0;
    end else begin
      line_finish_r <= 1'b0;
      if (I_PIXEL_BIT_CLOCK && bit_cnt_r != `LPCC_BIT_LAST) begin
        bit_cnt_r     <= bit_cnt_r + 9'h1;
        line_finish_r <= (bit_cnt_r == `LPCC_BIT_LAST - 9'h1);
      end
    end
  end

  // Line counter, cleared by the frame reset.
  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST || I_FRAME_RESET) begin
      line_cnt_r <= 8'h0;
    end else if (line_increment_pulse) begin
      line_cnt_r <= line_cnt_r + 8'h1;
    end
  end

  // Deglitch counter; it parks at terminal count so stray hits mid-count change nothing.
  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      dg_cnt_r <= `LPCC_DG_TERMINAL;
      qhit_d_r <= 1'b0;
    end else begin
      qhit_d_r <= qualified_pen_hit;
      if (deglitch_terminal_count && qhit_pulse) begin
        dg_cnt_r <= 4'h0;
      end else if (!deglitch_terminal_count && line_increment_pulse) begin
        dg_cnt_r <= dg_cnt_r + 4'h1;
      end
    end
  end

  // Two-stage capture: the hit arms, the next bit clock fires the pulse.
  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      arm_r <= 1'b0;
      stb_r <= 1'b0;
    end else begin
      stb_r <= arm_r && I_PIXEL_BIT_CLOCK;
      if (arm_r && I_PIXEL_BIT_CLOCK) begin
        arm_r <= 1'b0;
      end else if (qhit_pulse && !locked_r && !deglitch_terminal_count &&
                   dg_cnt_r == adp_r.portb[7:4]) begin
        arm_r <= 1'b1;
      end
    end
  end

  // Lockout after a capture; a new capture in the release cycle keeps it locked.
  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      locked_r <= 1'b0;
    end else if (stb_r && (lock_sel == LPCC_LOCK_FRAME || lock_sel == LPCC_LOCK_LINE)) begin
      locked_r <= 1'b1;
    end else if ((lock_sel == LPCC_LOCK_FRAME && I_FRAME_RESET) ||
                 (lock_sel == LPCC_LOCK_LINE && I_LINE_RESET) ||
                 lock_sel == LPCC_LOCK_NONE || lock_sel == LPCC_LOCK_OFF2) begin
      locked_r <= 1'b0;
    end
  end

  // Coordinate latches; they change only on the capture pulse.
  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      coord_r <= '0;
    end else if (stb_r) begin
      coord_r.horiz <= bit_cnt_r;
      coord_r.line  <= line_cnt_r;
    end
  end

  // Picture invert with hit cursor; touch masks the cursor so the pen sees the real image.
  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      invert_r <= 1'b0;
      line_clock_to_timer_r   <= 1'b0;
    end else begin
      invert_r <= adp_r.mode[5] ^ (adp_r.mode[6] && !I_PEN_HIT_N && I_PEN_TOUCH_N);
      line_clock_to_timer_r   <= line_increment_pulse;
    end
  end

  // Address phase register: select, direction and low address bits.
  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      aph_r <= '0;
    end else if (I_HREADY) begin
      aph_r.wr  <= aph_valid && I_HWRITE;
      aph_r.rd  <= aph_valid && !I_HWRITE;
      aph_r.ofs <= I_HADDR[3:0];
    end
  end

  // Read data is fetched at the address phase so the data phase needs no wait state.
  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      hrdata_r <= 32'h0;
    end else if (aph_valid && !I_HWRITE) begin
      hrdata_r <= read_value(I_HADDR[3:0], coord_r, adapter_word);
    end
  end

  // Adapter ports and pen flags; a flag set beats a clear in the same cycle.
  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      adp_r.mode     <= `LPCC_MODE_RST;
      adp_r.portb    <= `LPCC_PORTB_RST;
      adp_r.touch_en <= 1'b0;
      adp_r.hit_en   <= 1'b0;
    end else if (aph_r.wr && aph_r.ofs == `LPCC_OFS_ADAPTER) begin
      adp_r.mode     <= I_HWDATA[`LPCC_MODE_MSB:`LPCC_MODE_LSB];
      adp_r.portb    <= I_HWDATA[`LPCC_PORTB_MSB:`LPCC_PORTB_LSB];
      adp_r.touch_en <= I_HWDATA[`LPCC_TOUCH_EN_BIT];
      adp_r.hit_en   <= I_HWDATA[`LPCC_HIT_EN_BIT];
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      touch_d_r        <= 1'b0;
      hit_d_r          <= 1'b0;
      adp_r.touch_flag <= 1'b0;
      adp_r.hit_flag   <= 1'b0;
    end else begin
      touch_d_r <= !I_PEN_TOUCH_N;
      hit_d_r   <= !I_PEN_HIT_N;
      if (!I_PEN_TOUCH_N && !touch_d_r) begin
        adp_r.touch_flag <= 1'b1;
      end else if (aph_r.wr && aph_r.ofs == `LPCC_OFS_ADAPTER && I_HWDATA[`LPCC_TOUCH_FLAG_BIT]) begin
        adp_r.touch_flag <= 1'b0;
      end
      if (!I_PEN_HIT_N && !hit_d_r) begin
        adp_r.hit_flag <= 1'b1;
      end else if (aph_r.wr && aph_r.ofs == `LPCC_OFS_ADAPTER && I_HWDATA[`LPCC_HIT_FLAG_BIT]) begin
        adp_r.hit_flag <= 1'b0;
      end
    end
  end

  // Output registers; the irq lines lag the flags by one cycle.
  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      O_TOUCH_IRQ <= 1'b0;
      O_HIT_IRQ   <= 1'b0;
      O_HREADYOUT <= 1'b0;
    end else begin
      O_TOUCH_IRQ <= adp_r.touch_flag && adp_r.touch_en;
      O_HIT_IRQ   <= adp_r.hit_flag && adp_r.hit_en;
      O_HREADYOUT <= 1'b1;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      O_HRESP <= 1'b0;
    end else begin
      O_HRESP <= 1'b0;
    end
  end

  assign O_HRDATA                   = hrdata_r;
  assign O_MODE_SELECT_BITS         = adp_r.mode;
  assign O_SYNC_SKIP_LINES          = adp_r.portb[3:0];
  assign O_INVERT                   = invert_r;
  assign O_LINE_CLOCK_TO_TIMER      = line_clock_to_timer_r;
  assign O_COORDINATE_CAPTURE_PULSE = stb_r;

  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_NRST);

  sequence s_arm_then_bit;
    arm_r ##0 I_PIXEL_BIT_CLOCK;
  endsequence

  sequence s_park_hit;
    deglitch_terminal_count ##0 qhit_pulse;
  endsequence

  AST_BIT_ADVANCE: assert property (
    I_PIXEL_BIT_CLOCK && !I_LINE_RESET && bit_cnt_r != `LPCC_BIT_LAST |=> bit_cnt_r == $past(bit_cnt_r) + 9'h1)
    else $error("Bit counter did not advance.");
  AST_HORIZ_LATCH: assert property (
    stb_r |=> coord_r.horiz == $past(bit_cnt_r))
    else $error("Horizontal latch missed capture.");
  AST_LINE_READ: assert property (
    aph_valid && !I_HWRITE && I_HADDR[3:0] == `LPCC_OFS_LINE |=> O_HRDATA == {24'h0, $past(coord_r.line)})
    else $error("Line read returned wrong value.");
  AST_TC_REST: assert property (
    deglitch_terminal_count && !qhit_pulse |=> deglitch_terminal_count)
    else $error("Deglitch counter left terminal without a hit.");
  AST_HIT_RESET: assert property (
    s_park_hit |=> dg_cnt_r == 4'h0 ##1 !deglitch_terminal_count)
    else $error("Qualified hit did not clear the deglitch counter.");
  AST_CAPTURE_SEQ: assert property (
    s_arm_then_bit |=> stb_r ##1 !stb_r)
    else $error("Armed hit did not give one capture pulse.");
  AST_LOCK_SET: assert property (
    stb_r && lock_sel == LPCC_LOCK_FRAME && !I_FRAME_RESET |=> locked_r)
    else $error("Frame lockout not applied.");
  AST_NO_LOCK: assert property (
    lock_sel == LPCC_LOCK_NONE || lock_sel == LPCC_LOCK_OFF2 |=> !locked_r)
    else $error("Lockout held with lockout disabled.");
  AST_TOUCH_QUAL: assert property (
    adp_r.mode[4] && I_PEN_TOUCH_N |-> !qualified_pen_hit)
    else $error("Hit qualified without touch.");
  AST_HOLD: assert property (
    !stb_r |=> $stable(coord_r))
    else $error("Coordinates changed without capture.");

endmodule

// ---- testbench/lpcc_pen_model.sv ----
// Pen and display timing model: bit clocks, line resets and pen hits.
`timescale 1ns/10ps
module lpcc_pen_model (
  // Clock and reset.
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  // Control from the bench.
  input  wire logic       i_hit_en,
  input  wire logic [8:0] i_aim,
  // Display timing and pen.
  output logic            o_bit_clk,
  output logic            o_line_reset,
  output logic            o_hit_n
);
  logic [9:0] pos_r;

  // A few idle cycles follow the last bit so the end-of-line pulse comes before the line reset.
  always_ff @(posedge i_clk) begin
    if (!i_nrst || pos_r == 10'd515) begin
      pos_r <= 10'h0;
    end else begin
      pos_r <= pos_r + 10'h1;
    end
  end

  // The pen sees the dot for three bit times on every line while aimed; released it reads inactive.
  always_comb begin
    o_bit_clk    = i_nrst && (pos_r < 10'd512);
    o_line_reset = (pos_r == 10'd515);
    o_hit_n      = !(i_hit_en && (pos_r >= {1'b0, i_aim}) && (pos_r < {1'b0, i_aim} + 10'd3));
  end
endmodule

// ---- testbench/testbench.sv ----
// Self-checking testbench of the light pen coordinate capture block.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin err_count++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module testbench;
  logic        clk, nrst, hsel, hwrite, link, psel, fr, touch_n, hit_en;
  logic        hready, hresp, bitc, lres, hit_n, inv, lclk, cap, tirq, hirq, alt;
  logic [31:0] haddr, hwdata, hrdata, rdata;
  logic [1:0]  htrans;
  logic [8:0]  aim;
  logic [6:0]  mode;
  logic [3:0]  skip;
  int          err_count, n_tests, caps, c0;

  lpcc_top dut (.I_REF_CLK(clk), .I_NRST(nrst), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
    .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready), .O_HREADYOUT(hready),
    .O_HRESP(hresp), .O_HRDATA(hrdata), .I_LINK_PROC_UNIQUE(link), .I_PROC_ADDR_SEL(psel),
    .I_PIXEL_BIT_CLOCK(bitc), .I_ALT_LINE_PULSE(alt), .I_LINE_RESET(lres), .I_FRAME_RESET(fr),
    .I_PEN_HIT_N(hit_n), .I_PEN_TOUCH_N(touch_n), .O_MODE_SELECT_BITS(mode), .O_SYNC_SKIP_LINES(skip),
    .O_INVERT(inv), .O_LINE_CLOCK_TO_TIMER(lclk), .O_COORDINATE_CAPTURE_PULSE(cap),
    .O_TOUCH_IRQ(tirq), .O_HIT_IRQ(hirq));

  lpcc_pen_model pen (.i_clk(clk), .i_nrst(nrst), .i_hit_en(hit_en), .i_aim(aim),
    .o_bit_clk(bitc), .o_line_reset(lres), .o_hit_n(hit_n));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (cap === 1'b1) begin
      caps++;
    end
  end

  task automatic stop_test();
    $display("Checks %0d, errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // One single transfer; read data is taken at the edge that ends the data phase.
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rdata = hrdata;
  endtask

  // Aims the pen for n lines, optionally starting a new frame; the idle lines let the deglitcher rest.
  task automatic run(input int n, input logic new_frame, input logic [8:0] a, input int exp_caps);
    repeat (13) @(posedge clk iff lres === 1'b1);
    c0 = caps;
    fr     <= new_frame;
    aim    <= a;
    hit_en <= 1'b1;
    @(posedge clk);
    fr <= 1'b0;
    repeat (n) @(posedge clk iff lres === 1'b1);
    hit_en <= 1'b0;
    `CHK("captures", exp_caps, caps - c0)
  endtask

  task automatic coord(input logic [8:0] a, input logic [7:0] ln);
    logic [8:0] h;
    bus(1'b0, 32'h0000_2200, 32'h0);
    h[0] = rdata[0];
    `CHK("lsb word high bits", 31'h0, rdata[31:1])
    bus(1'b0, 32'h0000_2204, 32'h0);
    h[8:1] = rdata[7:0];
    `CHK("horiz near aim", 1'b1, (h >= a) && (h <= a + 9'd4))
    bus(1'b0, 32'h0000_2208, 32'h0);
    `CHK("line", {24'h0, ln}, rdata)
  endtask

  task automatic t_bus();
    `CHK("hresp", 1'b0, hresp)
    bus(1'b0, 32'h0000_220c, 32'h0);
    `CHK("adapter reset", 32'h0000_3002, rdata)
    `CHK("mode out", 7'h02, mode)
    bus(1'b1, 32'h0000_220c, 32'h0000_3502);
    @(posedge clk);
    `CHK("skip lines", 4'h5, skip)
    link <= 1'b1;
    bus(1'b1, 32'h0000_220c, 32'h0000_3702);
    psel <= 1'b1;
    bus(1'b0, 32'h0000_220c, 32'h0);
    `CHK("other processor ignored", 32'h0000_3502, rdata)
    bus(1'b1, 32'h0000_220c, 32'h0000_3002);
    bus(1'b0, 32'h0000_220c, 32'h0);
    `CHK("own processor taken", 32'h0000_3002, rdata)
    link <= 1'b0;
    psel <= 1'b0;
    bus(1'b0, 32'h0000_2300, 32'h0);
    `CHK("outside window", 32'h0000_3002, rdata)
  endtask

  task automatic t_capture();
    run(4, 1'b1, 9'd100, 1);
    coord(9'd100, 8'd3);
    run(3, 1'b1, 9'd200, 0);
    coord(9'd100, 8'd3);
  endtask

  task automatic t_lock();
    bus(1'b1, 32'h0000_220c, 32'h0000_3000);
    run(4, 1'b1, 9'd150, 1);
    run(4, 1'b0, 9'd300, 0);
    run(4, 1'b1, 9'd300, 1);
    coord(9'd300, 8'd3);
    bus(1'b1, 32'h0000_220c, 32'h0000_3001);
    run(4, 1'b0, 9'd120, 1);
  endtask

  task automatic t_touch();
    bus(1'b1, 32'h0000_220c, 32'h000c_1012);
    run(2, 1'b1, 9'd60, 0);
    `CHK("hit irq", 1'b1, hirq)
    `CHK("touch irq idle", 1'b0, tirq)
    bus(1'b1, 32'h0000_220c, 32'h000e_1012);
    repeat (3) @(posedge clk);
    `CHK("hit irq cleared", 1'b0, hirq)
    touch_n <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK("touch irq", 1'b1, tirq)
    run(2, 1'b1, 9'd60, 1);
    coord(9'd60, 8'd1);
    touch_n <= 1'b1;
    bus(1'b1, 32'h0000_220c, 32'h000d_1012);
    repeat (3) @(posedge clk);
    `CHK("touch irq cleared", 1'b0, tirq)
  endtask

  task automatic t_invert();
    bus(1'b1, 32'h0000_220c, 32'h0000_3022);
    repeat (3) @(posedge clk);
    `CHK("whole invert", 1'b1, inv)
    bus(1'b1, 32'h0000_220c, 32'h0000_3042);
    aim    <= 9'd10;
    hit_en <= 1'b1;
    @(posedge clk iff hit_n === 1'b0);
    @(posedge clk);
    `CHK("cursor", 1'b1, inv)
    touch_n <= 1'b0;
    @(posedge clk iff hit_n === 1'b0);
    @(posedge clk);
    `CHK("cursor under touch", 1'b0, inv)
    hit_en  <= 1'b0;
    touch_n <= 1'b1;
    // The own end-of-line pulse reaches the timer line one cycle after the last bit.
    @(posedge clk iff lres === 1'b1);
    repeat (512) @(posedge clk);
    `CHK("line clock early", 1'b0, lclk)
    @(posedge clk);
    `CHK("line clock", 1'b1, lclk)
    // Another sync source supplies the line pulse through the multiplexer.
    bus(1'b1, 32'h0000_220c, 32'h0000_3006);
    @(posedge clk iff lres === 1'b1);
    alt <= 1'b1;
    @(posedge clk);
    alt <= 1'b0;
    @(posedge clk);
    `CHK("alt line clock", 1'b1, lclk)
    @(posedge clk);
    `CHK("alt line clock end", 1'b0, lclk)
  endtask

  initial begin
    {nrst, hsel, hwrite, link, psel, fr, hit_en, htrans} = '0;
    touch_n = 1'b1;
    alt     = 1'b0;
    haddr   = 32'h0;
    hwdata  = 32'h0;
    aim     = 9'h0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    t_bus();
    t_capture();
    t_lock();
    t_touch();
    t_invert();
    stop_test();
  end

  // The scenarios take about 70000 cycles.
  initial begin
    #950000;
    err_count++;
    stop_test();
  end
endmodule
